/* include/qdac_defines.vh */
`ifndef QDAC_DEFINES_VH
`define QDAC_DEFINES_VH

// Serial word layout
`define QDAC_WORD_BITS      16
`define QDAC_CNT_W          5
`define QDAC_SEL_HI_BIT     15
`define QDAC_SEL_LO_BIT     14
`define QDAC_PWR_DN_N_BIT   13
`define QDAC_LOAD_ALL_N_BIT 12
`define QDAC_DATA_MSB       11
`define QDAC_DATA_W         12
`define QDAC_CHANNELS       4
`define QDAC_LAST_CNT       5'h0F

// Register bus map (byte addresses)
`define QDAC_ADDR_W         5
`define QDAC_OFF_STATUS     5'h00
`define QDAC_OFF_CTRL       5'h04
`define QDAC_OFF_IN_BASE    5'h08
`define QDAC_OFF_OUT_BASE   5'h10

// Reset values
`define QDAC_RST_DATA       12'h000
`define QDAC_RST_PWR_OK     1'b1
`define QDAC_RST_ENABLE     1'b1

`endif

/* verilog/qdac_serial_port.v */
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "qdac_defines.vh"

module qdac_serial_port
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Serial pins
  input  wire        i_sclk,
  input  wire        i_din,
  input  wire        i_frame_n,
  // AHB-Lite slave
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  // Converter state
  output reg         o_power_down_n,
  output reg         o_word_done,
  output reg  [47:0] o_out_codes
);

  reg  [2:0]                      sclk_sync_ff;
  reg  [2:0]                      frame_sync_ff;
  reg  [1:0]                      din_sync_ff;
  reg  [`QDAC_WORD_BITS-1:0]      shift_ff;
  reg  [`QDAC_CNT_W-1:0]          cnt_ff;
  reg                             active_ff;
  reg                             enable_ff;
  // Event counters wrap at 255
  reg  [7:0]                      aborts_ff;
  reg  [7:0]                      words_ff;
  reg  [`QDAC_DATA_W-1:0]         in_reg_ff  [0:`QDAC_CHANNELS-1];
  reg  [`QDAC_DATA_W-1:0]         out_reg_ff [0:`QDAC_CHANNELS-1];
  // Bus data phase state
  reg                             ph_wr_ff;
  reg  [`QDAC_ADDR_W-1:0]         ph_addr_ff;

  // Edges of the synchronised pins
  wire                            sclk_fall  = sclk_sync_ff[2] & ~sclk_sync_ff[1];
  wire                            frame_fall = frame_sync_ff[2] & ~frame_sync_ff[1];
  wire                            frame_rise = ~frame_sync_ff[2] & frame_sync_ff[1];
  // One stage late, so a rise together with the last fall still completes
  wire                            frame_low  = ~frame_sync_ff[2];
  wire [`QDAC_WORD_BITS-1:0]      nxt_shift  = {shift_ff[`QDAC_WORD_BITS-2:0], din_sync_ff[1]};
  wire                            last_bit   = (cnt_ff == `QDAC_LAST_CNT);
  wire                            take_bit   = active_ff & frame_low & sclk_fall;
  wire                            word_end   = take_bit & last_bit;
  wire [1:0]                      word_chan  = {nxt_shift[`QDAC_SEL_HI_BIT], nxt_shift[`QDAC_SEL_LO_BIT]};
  wire [`QDAC_DATA_W-1:0]         word_data  = nxt_shift[`QDAC_DATA_MSB:0];
  wire                            addr_phase = i_hsel & i_hready & i_htrans[1];

  // Register index decode, shared by read mux and write path
  function [2:0] reg_idx;
    input [`QDAC_ADDR_W-1:0] a;
    begin
      reg_idx = a[4:2];
    end
  endfunction

  // Sync stage 0 only feeds stage 1; edges come from stages 1 and 2
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sclk_sync_ff  <= 3'h0;
      // Frame select idles high: no false start after reset
      frame_sync_ff <= 3'h7;
      din_sync_ff   <= 2'h0;
    end
    else
    begin
      sclk_sync_ff  <= {sclk_sync_ff[1:0], i_sclk};
      frame_sync_ff <= {frame_sync_ff[1:0], i_frame_n};
      din_sync_ff   <= {din_sync_ff[0], i_din};
    end
  end

  // Frame capture
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      shift_ff    <= 16'h0000;
      cnt_ff      <= 5'h00;
      active_ff   <= 1'b0;
      aborts_ff   <= 8'h00;
      words_ff    <= 8'h00;
      o_word_done <= 1'b0;
    end
    else
    begin
      o_word_done <= word_end;
      // Priority: start, completed word, abort, plain bit
      if (frame_fall & enable_ff)
      begin
        active_ff <= 1'b1;
        cnt_ff    <= 5'h00;
      end
      else if (word_end)
      begin
        // Last bit beats a frame rise in the same cycle
        shift_ff  <= nxt_shift;
        active_ff <= 1'b0;
        words_ff  <= words_ff + 8'h01;
      end
      else if (frame_rise)
      begin
        if (active_ff)
          aborts_ff <= aborts_ff + 8'h01;
        active_ff <= 1'b0;
      end
      else if (take_bit)
      begin
        shift_ff <= nxt_shift;
        cnt_ff   <= cnt_ff + 5'h01;
      end
    end
  end

  // Converter registers
  genvar g;
  generate
    for (g = 0; g < `QDAC_CHANNELS; g = g + 1)
    begin : g_chan
      always @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          in_reg_ff[g]  <= `QDAC_RST_DATA;
          out_reg_ff[g] <= `QDAC_RST_DATA;
        end
        else if (word_end)
        begin
          // Addressed input register; outputs only when load bit low
          if ({30'h00000000, word_chan} == g)
            in_reg_ff[g] <= word_data;
          if (!nxt_shift[`QDAC_LOAD_ALL_N_BIT])
            out_reg_ff[g] <= ({30'h00000000, word_chan} == g) ? word_data : in_reg_ff[g];
        end
      end
      // Codes leave through a flop, one clock behind the registers
      always @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          o_out_codes[g*`QDAC_DATA_W +: `QDAC_DATA_W] <= `QDAC_RST_DATA;
        else
          o_out_codes[g*`QDAC_DATA_W +: `QDAC_DATA_W] <= out_reg_ff[g];
      end
    end
  endgenerate

  // Power state follows the last complete word
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_power_down_n <= `QDAC_RST_PWR_OK;
    else if (word_end)
      o_power_down_n <= nxt_shift[`QDAC_PWR_DN_N_BIT];
  end

  // Bus slave
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      enable_ff      <= `QDAC_RST_ENABLE;
      ph_wr_ff       <= 1'b0;
      ph_addr_ff     <= 5'h00;
      o_hrdata       <= 32'h00000000;
      o_hreadyout    <= 1'b1;
      o_hresp        <= 1'b0;
    end
    else
    begin
      ph_wr_ff   <= addr_phase & i_hwrite;
      ph_addr_ff <= i_haddr[`QDAC_ADDR_W-1:0];
      // Disabling only blocks new starts; a frame under way finishes
      if (ph_wr_ff && i_hready && reg_idx(ph_addr_ff) == reg_idx(`QDAC_OFF_CTRL))
        enable_ff <= i_hwdata[0];
      // Read data registered in address phase: zero wait states
      if (addr_phase & ~i_hwrite)
      begin
        // Unmapped offsets read as zero
        case (reg_idx(i_haddr[`QDAC_ADDR_W-1:0]))
          3'd0:    o_hrdata <= {8'h00, words_ff, aborts_ff, 6'h00, active_ff, o_power_down_n};
          3'd1:    o_hrdata <= {31'h00000000, enable_ff};
          3'd2:    o_hrdata <= {in_reg_ff[1], 4'h0, in_reg_ff[0], 4'h0};
          3'd3:    o_hrdata <= {in_reg_ff[3], 4'h0, in_reg_ff[2], 4'h0};
          3'd4:    o_hrdata <= {out_reg_ff[1], 4'h0, out_reg_ff[0], 4'h0};
          3'd5:    o_hrdata <= {out_reg_ff[3], 4'h0, out_reg_ff[2], 4'h0};
          default: o_hrdata <= 32'h00000000;
        endcase
      end
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

endmodule // qdac_serial_port

/* testbench/qdac_serial_port_monitor.sv */
`timescale 1ns/100ps
module qdac_mon
(
  input wire        i_clk,
  input wire        i_rst_n,
  input wire        i_frame_n,
  input wire        o_hreadyout,
  input wire        o_hresp,
  input wire        o_power_down_n,
  input wire        o_word_done,
  input wire [47:0] o_out_codes
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence done_s;
    o_word_done;
  endsequence
  // One pulse per frame, no further pulse in the 8 cycles after it
  done_pulse_a: assert property (done_s |=> !o_word_done [*8]) else $error("done repeated");
  done_in_frame_a: assert property (done_s |-> !$past(i_frame_n, 4)) else $error("done outside frame");
  // Frame select was already low 124 clocks back
  frame_long_a: assert property (done_s |-> !$past(i_frame_n, 124)) else $error("word too short");
  quiet_idle_a: assert property (i_frame_n [*8] |-> !o_word_done) else $error("done while idle");
  codes_on_done_a: assert property ($changed(o_out_codes) |-> $past(o_word_done)) else $error("codes moved");
  pwr_on_done_a: assert property ($changed(o_power_down_n) |-> o_word_done || $past(o_word_done))
    else $error("power moved");
  reset_state_a: assert property ($rose(i_rst_n) |-> o_out_codes == 48'h0 && o_power_down_n)
    else $error("bad reset state");
  bus_okay_a: assert property (o_hreadyout && !o_hresp) else $error("bus not okay");
endmodule // qdac_mon

/* testbench/qdac_ctl_model.sv */
`timescale 1ns/100ps
module qdac_ctl_model
(
  input  wire i_clk,
  output reg  o_sclk,
  output reg  o_din,
  output reg  o_frame_n
);
  initial {o_sclk, o_din, o_frame_n} = 3'b101;
  task automatic send(input [15:0] w, input int n);
    int i;
    o_frame_n <= 1'b0;
    for (i = 0; i < n; i++)
    begin
      o_din <= (i < 16) ? w[15 - i] : ~o_din;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
    repeat (8) @(posedge i_clk);
    o_frame_n <= 1'b1;
    // Released line must not echo the last bit
    o_din <= ~o_din;
    repeat (8) @(posedge i_clk);
  endtask
endmodule // qdac_ctl_model

/* testbench/quad_dac_serial_write_port_tb.sv */
`timescale 1ns/100ps
module quad_dac_serial_write_port_tb;
  reg         i_clk = 1'b0;
  reg         i_rst_n = 1'b0;
  reg         i_hsel = 1'b0;
  reg  [31:0] i_haddr = 32'h0;
  reg  [1:0]  i_htrans = 2'h0;
  reg         i_hwrite = 1'b0;
  reg  [31:0] i_hwdata = 32'h0;
  wire [31:0] o_hrdata;
  wire        o_hreadyout, o_hresp, o_power_down_n, o_word_done, s, d, f;
  wire [47:0] o_out_codes;
  int         fails = 0, total_checks = 0, cyc = 0;
  always #25 i_clk = ~i_clk;
  qdac_ctl_model ctl (.i_clk, .o_sclk(s), .o_din(d), .o_frame_n(f));
  qdac_serial_port dut (.i_clk, .i_rst_n, .i_sclk(s), .i_din(d), .i_frame_n(f), .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp,
    .o_power_down_n, .o_word_done, .o_out_codes);
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [47:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input [31:0] a, wd, input w, input [31:0] e);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    if (!w)
      chk({16'h0, o_hrdata}, {16'h0, e});
  endtask
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk(o_out_codes, 48'h0);
    bus(32'h0, 0, 0, 32'h1);
    ctl.send(16'h5ABC, 16);
    bus(32'h8, 0, 0, 32'hABC00000);
    chk(o_out_codes, 48'h0);
    ctl.send(16'hA5A5, 18);
    chk(o_out_codes, 48'h0005A5ABC000);
    bus(32'hC, 0, 0, 32'h00005A50);
    ctl.send(16'h1FFF, 10);
    bus(32'h8, 0, 0, 32'hABC00000);
    bus(32'h0, 0, 0, 32'h00020101);
    ctl.send(16'hD123, 16);
    chk({47'h0, o_power_down_n}, 48'h0);
    bus(32'hC, 0, 0, 32'h12305A50);
    // Disabled port must drop the whole frame
    bus(32'h4, 0, 1, 0);
    bus(32'h4, 0, 0, 32'h0);
    ctl.send(16'h7FFF, 16);
    bus(32'h0, 0, 0, 32'h00030100);
    chk(o_out_codes, 48'h0005A5ABC000);
    bus(32'h10, 0, 0, 32'hABC00000);
    bus(32'h14, 0, 0, 32'h00005A50);
    bus(32'h18, 0, 0, 32'h0);
    bus(32'h4, 1, 1, 0);
    ctl.send(16'h2FED, 16);
    chk(o_out_codes, 48'h1235A5ABCFED);
    chk({47'h0, o_power_down_n}, 48'h1);
    bus(32'h0, 0, 0, 32'h00040101);
    end_of_test;
  end
endmodule // quad_dac_serial_write_port_tb
bind qdac_serial_port qdac_mon mon (.i_clk, .i_rst_n, .i_frame_n, .o_hreadyout, .o_hresp, .o_power_down_n,
  .o_word_done, .o_out_codes);
